//--- memory_map_defs.svh
// Address map constants for the external memory map decoder.
// Assumes a 32-bit byte address space and the bus size codes below.
`ifndef MEMORY_MAP_DEFS_SVH
`define MEMORY_MAP_DEFS_SVH

// Region base addresses; boot PROM, exchange memory and RAM end at their coded size and reach the next base only at code 7
`define BOOT_PROM_BASE  32'h0000_0000
`define XPROM_BASE      32'h0100_0000
`define EXCH_BASE       32'h01f0_0000
`define SYSREG_BASE     32'h01f8_0000
`define RAM_BASE        32'h0200_0000
`define XRAM_BASE       32'h0400_0000
`define IO_BASE         32'h1000_0000
`define XIO_BASE        32'h1400_0000
`define XGEN_BASE       32'h8000_0000

// Smallest sizes; a 3-bit size code doubles them per step
`define PROM_MIN_SIZE   32'h0002_0000
`define EXCH_MIN_SIZE   32'h0000_1000
`define RAM_MIN_TOTAL   32'h0004_0000
`define RAM_BLK_SHIFT   5'h0f

// Bus size codes
`define SZ_BYTE         2'h0
`define SZ_WORD         2'h2

// Bus-ready time-out, in system clock cycles
`define READY_TIMEOUT   256

`endif

//--- memory_map_pkg.sv
// Types shared by the memory map decoder and its surroundings.
// Assumes the constants header is included alongside.
package memory_map_pkg;

  typedef enum logic [3:0] {
    RGN_NONE, RGN_BOOT, RGN_XPROM, RGN_EXCH, RGN_SYS,
    RGN_RAM, RGN_XRAM, RGN_IO, RGN_XIO, RGN_XGEN
  } region_t;

  typedef enum logic [1:0] {ERR_NONE, ERR_ILLEGAL, ERR_SIZE, ERR_TIMEOUT} err_t;

  typedef struct packed {
    logic [31:0] addr;
    logic [1:0]  size;
    logic        write;
    logic [31:0] wdata;
  } req_t;

  typedef struct packed {
    logic done;
    err_t err;
  } resp_t;

endpackage

//--- memory_map_decoder.sv
// Address decoder and access checker for the external address space.
// Assumes one request at a time from the integer unit, held with req_valid
// until req_ready; config inputs are static while an access runs.
`timescale 1ns/1ns
`include "memory_map_defs.svh"

// Summary of operation
// - Boot PROM at address zero, size 128K to 16M by code.
// - Narrow PROM: no parity, no EDAC, byte writes only.
// - Wide PROM: parity and EDAC always, word writes only.
// - Extended PROM from 0x01000000, up to 15M, same width options.
// - Exchange memory from 0x01F00000, 4K to 512K, word writes only.
// - System registers window 0x01F80000, parity, word access only.
// - Main RAM from 0x02000000, eight equal blocks, all sizes.
// - Extended RAM from 0x04000000, up to 192M.
// - Four I/O areas at 16M steps from 0x10000000, parity optional.
// - Extended I/O from 0x14000000, up to 1728M.
// - Extended general from 0x80000000, no parity, all sizes.
// - Narrow PROM uses a latched byte-lane address per fetched byte.
// - Unmapped addresses are caught and flagged illegal.
// - Ready-completed regions time out after 256 cycles.
// - Data parity line carries odd parity over 32 data bits.
module memory_map_decoder
  import memory_map_pkg::*;
#(
  parameter int RAM_BLOCKS = 8
) (
  // Clock and reset
  input  wire logic        core_clk,
  input  wire logic        rstn,
  // Access request and answer
  input  wire logic        req_valid,
  input  wire req_t        req,
  output logic             req_ready,
  output resp_t            resp,
  // Static configuration
  input  wire logic        narrow_prom_select_n,
  input  wire logic [2:0]  prom_size_code,
  input  wire logic [2:0]  exch_size_code,
  input  wire logic [2:0]  ram_size_code,
  input  wire logic        ram_parity_en,
  input  wire logic        ram_edac_en,
  input  wire logic        exch_parity_en,
  input  wire logic        exch_edac_en,
  input  wire logic        io_parity_en,
  // External bus ready
  input  wire logic        external_ready_n,
  // Chip selects
  output logic             prom_select_n,
  output logic             exchange_mem_select_n,
  output logic [9:0]       ram_bank_select_n,
  output logic [3:0]       io_area_select_n,
  output logic             ext_area_select_n,
  // Narrow PROM lane and data protection
  output logic [1:0]       byte_lane,
  output logic             data_parity_line,
  output logic             parity_active,
  output logic             edac_active
);

  typedef enum logic {ST_IDLE, ST_BUSY} state_t;

  ////////////////////////////////////////////////////////////////////////////
  // Reset release through two flops
  logic rst_meta;
  logic rst_sync;
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      rst_meta <= 1'b0;
      rst_sync <= 1'b0;
    end else begin
      rst_meta <= 1'b1;
      rst_sync <= rst_meta;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Address decode
  region_t     region;
  logic [2:0]  blk_idx;
  logic [31:0] ram_off;
  logic [31:0] prom_lim;
  logic [31:0] exch_lim;
  logic [31:0] ram_lim;
  logic        narrow;
  logic        size_bad;
  logic        accept;
  logic        par_en;
  logic        edac_en;
  logic        wait_rdy;

  assign prom_lim = `PROM_MIN_SIZE << prom_size_code;
  assign exch_lim = `EXCH_MIN_SIZE << exch_size_code;
  assign ram_lim  = `RAM_MIN_TOTAL << ram_size_code;
  assign ram_off  = req.addr - `RAM_BASE;
  assign narrow   = !narrow_prom_select_n;
  assign accept   = req_valid && req_ready;

  // First match wins; gaps fall through to RGN_NONE
  always_comb begin
    region  = RGN_NONE;
    blk_idx = 3'h0;
    if (req.addr < `BOOT_PROM_BASE + prom_lim) begin
      region = RGN_BOOT;
    end else if (req.addr >= `XPROM_BASE && req.addr < `EXCH_BASE) begin
      region = RGN_XPROM;
    end else if (req.addr >= `EXCH_BASE && req.addr < `EXCH_BASE + exch_lim) begin
      region = RGN_EXCH;
    end else if (req.addr >= `SYSREG_BASE && req.addr < `RAM_BASE) begin
      region = RGN_SYS;
    end else if (req.addr >= `RAM_BASE && ram_off < ram_lim) begin
      region  = RGN_RAM;
      blk_idx = 3'(ram_off >> (`RAM_BLK_SHIFT + 5'(ram_size_code)));
    end else if (req.addr >= `XRAM_BASE && req.addr < `IO_BASE) begin
      region = RGN_XRAM;
    end else if (req.addr >= `IO_BASE && req.addr < `XIO_BASE) begin
      region = RGN_IO;
    end else if (req.addr >= `XIO_BASE && req.addr < `XGEN_BASE) begin
      region = RGN_XIO;
    end else if (req.addr >= `XGEN_BASE) begin
      region = RGN_XGEN;
    end
  end

  // Width policy and protection per region
  always_comb begin
    size_bad = 1'b0;
    par_en   = 1'b0;
    edac_en  = 1'b0;
    wait_rdy = 1'b0;
    unique case (region)
      RGN_BOOT, RGN_XPROM: begin
        wait_rdy = (region == RGN_XPROM);
        if (narrow) begin
          size_bad = req.write && req.size != `SZ_BYTE;
        end else begin
          // wide PROM, parity and EDAC forced
          size_bad = req.write && req.size != `SZ_WORD;
          par_en   = 1'b1;
          edac_en  = 1'b1;
        end
      end
      RGN_EXCH: begin
        size_bad = req.write && req.size != `SZ_WORD;
        par_en   = exch_parity_en || exch_edac_en;
        edac_en  = exch_edac_en;
        wait_rdy = 1'b1;
      end
      RGN_SYS: begin
        size_bad = req.size != `SZ_WORD;
        par_en   = 1'b1;
      end
      RGN_RAM, RGN_XRAM: begin
        par_en   = ram_parity_en || ram_edac_en;
        edac_en  = ram_edac_en;
        wait_rdy = (region == RGN_XRAM);
      end
      RGN_IO, RGN_XIO: begin
        par_en   = io_parity_en;
        wait_rdy = (region == RGN_XIO);
      end
      RGN_XGEN: wait_rdy = 1'b1;
      RGN_NONE: size_bad = 1'b0;
      default:  size_bad = 1'b0;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // Access sequencer
  state_t     st;
  state_t     next_st;
  logic [7:0] timer;
  logic [7:0] next_timer;
  logic [1:0] last_lane;
  logic [1:0] next_last_lane;
  logic       multi;
  logic       next_multi;
  logic       waits;
  logic       next_waits;
  logic       next_req_ready;
  resp_t      next_resp;
  logic       next_prom_select_n;
  logic       next_exchange_mem_select_n;
  logic [9:0] next_ram_bank_select_n;
  logic [3:0] next_io_area_select_n;
  logic       next_ext_area_select_n;
  logic [1:0] next_byte_lane;
  logic       next_data_parity_line;
  logic       next_parity_active;
  logic       next_edac_active;
  logic       beat;

  assign beat = !waits || !external_ready_n;

  always_comb begin
    next_st                    = st;
    next_timer                 = timer;
    next_last_lane             = last_lane;
    next_multi                 = multi;
    next_waits                 = waits;
    next_resp                  = '{done: 1'b0, err: ERR_NONE};
    next_prom_select_n         = prom_select_n;
    next_exchange_mem_select_n = exchange_mem_select_n;
    next_ram_bank_select_n     = ram_bank_select_n;
    next_io_area_select_n      = io_area_select_n;
    next_ext_area_select_n     = ext_area_select_n;
    next_byte_lane             = byte_lane;
    next_data_parity_line      = data_parity_line;
    next_parity_active         = parity_active;
    next_edac_active           = edac_active;
    unique case (st)
      ST_IDLE: begin
        if (accept) begin
          next_parity_active = par_en;
          next_edac_active   = edac_en;
          next_data_parity_line = par_en && req.write && !(^req.wdata);
          if (region == RGN_NONE) begin
            next_resp = '{done: 1'b1, err: ERR_ILLEGAL};
          end else if (size_bad) begin
            next_resp = '{done: 1'b1, err: ERR_SIZE};
          end else if (region == RGN_SYS) begin
            next_resp = '{done: 1'b1, err: ERR_NONE};
          end else begin
            next_prom_select_n         = !(region == RGN_BOOT || region == RGN_XPROM);
            next_exchange_mem_select_n = !(region == RGN_EXCH);
            next_ext_area_select_n     = !(region == RGN_XRAM || region == RGN_XIO ||
                                           region == RGN_XGEN);
            if (region == RGN_RAM) begin
              next_ram_bank_select_n[blk_idx] = 1'b0;
            end
            if (region == RGN_IO) begin
              next_io_area_select_n[req.addr[25:24]] = 1'b0;
            end
            // narrow reads walk the byte lanes
            next_byte_lane = req.addr[1:0];
            next_last_lane = req.addr[1:0] + ((req.size == `SZ_BYTE) ? 2'h0 :
                             (req.size == `SZ_WORD - 2'h1) ? 2'h1 : 2'h3);
            next_multi = narrow && !req.write &&
                         (region == RGN_BOOT || region == RGN_XPROM);
            next_waits = wait_rdy;
            next_timer = 8'h00;
            next_st    = ST_BUSY;
          end
        end
      end
      ST_BUSY: begin
        if (beat && multi && byte_lane != last_lane) begin
          next_byte_lane = byte_lane + 2'h1;
          next_timer     = 8'h00;
        end else if (beat || timer == 8'(`READY_TIMEOUT - 1)) begin
          next_resp = '{done: 1'b1, err: beat ? ERR_NONE : ERR_TIMEOUT};
          next_prom_select_n         = 1'b1;
          next_exchange_mem_select_n = 1'b1;
          next_ram_bank_select_n     = '1;
          next_io_area_select_n      = '1;
          next_ext_area_select_n     = 1'b1;
          next_st                    = ST_IDLE;
        end else begin
          next_timer = timer + 8'h01;
        end
      end
    endcase
    next_req_ready = (next_st == ST_IDLE);
  end

  // State registers; all outputs come from here
  always_ff @(posedge core_clk or negedge rst_sync) begin
    if (!rst_sync) begin
      st                    <= ST_IDLE;
      timer                 <= 8'h00;
      last_lane             <= 2'h0;
      multi                 <= 1'b0;
      waits                 <= 1'b0;
      req_ready             <= 1'b0;
      resp                  <= '{done: 1'b0, err: ERR_NONE};
      prom_select_n         <= 1'b1;
      exchange_mem_select_n <= 1'b1;
      ram_bank_select_n     <= '1;
      io_area_select_n      <= '1;
      ext_area_select_n     <= 1'b1;
      byte_lane             <= 2'h0;
      data_parity_line      <= 1'b0;
      parity_active         <= 1'b0;
      edac_active           <= 1'b0;
    end else begin
      st                    <= next_st;
      timer                 <= next_timer;
      last_lane             <= next_last_lane;
      multi                 <= next_multi;
      waits                 <= next_waits;
      req_ready             <= next_req_ready;
      resp                  <= next_resp;
      prom_select_n         <= next_prom_select_n;
      exchange_mem_select_n <= next_exchange_mem_select_n;
      ram_bank_select_n     <= next_ram_bank_select_n;
      io_area_select_n      <= next_io_area_select_n;
      ext_area_select_n     <= next_ext_area_select_n;
      byte_lane             <= next_byte_lane;
      data_parity_line      <= next_data_parity_line;
      parity_active         <= next_parity_active;
      edac_active           <= next_edac_active;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rst_sync);

  chk_illegal_flag: assert property (
    accept && region == RGN_NONE |=> resp.done && resp.err == ERR_ILLEGAL)
    else $error("unmapped access not flagged");
  chk_timeout_bound: assert property (
    st == ST_BUSY && waits && timer == 8'hff && external_ready_n
    |=> resp.done && resp.err == ERR_TIMEOUT && st == ST_IDLE)
    else $error("missing bus time-out");
  chk_one_select: assert property (
    $countones({prom_select_n, exchange_mem_select_n, ram_bank_select_n,
                io_area_select_n, ext_area_select_n}) >= 16)
    else $error("more than one select active");
  chk_sys_noselect: assert property (
    accept && region == RGN_SYS && !size_bad
    |=> resp.done && parity_active && prom_select_n && &ram_bank_select_n)
    else $error("system register access misrouted");
  chk_parity_odd: assert property (
    accept && req.write && par_en
    |=> data_parity_line == !(^$past(req.wdata)))
    else $error("data parity not odd");
  chk_narrow_write: assert property (
    accept && narrow && (region == RGN_BOOT || region == RGN_XPROM) && req.write
    && req.size != `SZ_BYTE |=> resp.err == ERR_SIZE)
    else $error("wide write to narrow PROM taken");
  chk_prom_edac: assert property (
    !prom_select_n && !narrow |-> parity_active && edac_active)
    else $error("wide PROM without parity and EDAC");
  chk_ram_select: assert property (
    accept && region == RGN_RAM |=> !ram_bank_select_n[$past(blk_idx)])
    else $error("wrong RAM block selected");
  chk_exch_word: assert property (
    accept && region == RGN_EXCH && req.write && req.size != `SZ_WORD
    |=> resp.err == ERR_SIZE && exchange_mem_select_n)
    else $error("narrow write to exchange memory taken");

endmodule

//--- ready_responder.sv
// Far-side model of the external devices that complete accesses by ready.
// Assumes active is high while a ready-controlled select is asserted.
`timescale 1ns/1ns

module ready_responder (
  // Clock and reset
  input  wire logic       core_clk,
  input  wire logic       rstn,
  // Access seen on the selects, and answer style
  input  wire logic       active,
  input  wire logic       stall,
  input  wire logic [7:0] delay,
  // Ready back to the decoder
  output logic            external_ready_n
);
  logic [7:0] count;

  ////////////////////////////////
  // One ready pulse per beat after delay cycles; idle level is high, as if pulled up.
  // A stalled device never answers, so the decoder must give up by itself.
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      count <= 8'h00;
      external_ready_n <= 1'b1;
    end else if (active && !stall && count == delay) begin
      count <= 8'h00;
      external_ready_n <= 1'b0;
    end else begin
      count <= active ? count + 8'h01 : 8'h00;
      external_ready_n <= 1'b1;
    end
  end
endmodule

//--- memory_map_decoder_bench.sv
// Self-checking bench for the memory map decoder.
// Assumes inputs change at the falling edge and the design takes at the rising one.
`timescale 1ns/1ns
`include "memory_map_defs.svh"

module memory_map_decoder_bench import memory_map_pkg::*;
;
  logic        core_clk, rstn, req_valid, req_ready, narrow_n, stall;
  logic        prom_select_n, exchange_mem_select_n, ext_area_select_n;
  logic        external_ready_n, data_parity_line, parity_active, edac_active;
  logic [9:0]  ram_bank_select_n;
  logic [3:0]  io_area_select_n;
  logic [1:0]  byte_lane;
  logic [4:0]  en;
  logic [16:0] sel;
  req_t        req;
  resp_t       resp;
  err_t        got_err;
  logic [1:0]  lanes[$];
  int          cyc, n_mismatch, checks;

  ////////////////////////////////
  // Design, with all size codes at their smallest settings
  memory_map_decoder memory_map_decoder_inst (
    .core_clk(core_clk), .rstn(rstn), .req_valid(req_valid), .req(req),
    .req_ready(req_ready), .resp(resp), .narrow_prom_select_n(narrow_n),
    .prom_size_code(3'h0), .exch_size_code(3'h0), .ram_size_code(3'h0),
    .ram_parity_en(en[0]), .ram_edac_en(en[1]), .exch_parity_en(en[2]),
    .exch_edac_en(en[3]), .io_parity_en(en[4]), .external_ready_n(external_ready_n),
    .prom_select_n(prom_select_n), .exchange_mem_select_n(exchange_mem_select_n),
    .ram_bank_select_n(ram_bank_select_n), .io_area_select_n(io_area_select_n),
    .ext_area_select_n(ext_area_select_n), .byte_lane(byte_lane),
    .data_parity_line(data_parity_line), .parity_active(parity_active),
    .edac_active(edac_active));

  ready_responder ready_responder_inst (
    .core_clk(core_clk), .rstn(rstn), .stall(stall), .delay(8'h02),
    .active(!prom_select_n || !exchange_mem_select_n || !ext_area_select_n),
    .external_ready_n(external_ready_n));

  ////////////////////////////////
  // Clock, 100 ns period
  initial begin
    core_clk = 1'b0;
    forever #50 core_clk = ~core_clk;
  end

  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    checks++;
    if (exp !== got) begin
      n_mismatch++;
      $display("[ERR] %s expected %h seen %h", name, exp, got);
    end
  endtask

  task automatic finish_test();
    $display("checks %0d mismatches %0d", checks, n_mismatch);
    if (n_mismatch == 0 && checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  // Select vector {prom, exch, ram[9:0], io[3:0], ext} with bit k low
  function automatic logic [16:0] one_sel(input int k);
    one_sel = '1;
    if (k >= 0) one_sel[k] = 1'b0;
  endfunction

  // One access: held until taken, then selects and lanes gathered until done
  task automatic acc(input logic [31:0] a, input logic [1:0] sz, input logic w,
                     input logic [31:0] d);
    int n;
    n = 0;
    sel = '1;
    cyc = 1;
    lanes.delete();
    req_valid = 1'b1;
    req = '{addr: a, size: sz, write: w, wdata: d};
    while (req_ready !== 1'b1 && n < 20) begin
      @(negedge core_clk);
      n++;
    end
    @(negedge core_clk);
    req_valid = 1'b0;
    while (cyc < 400) begin
      sel &= {prom_select_n, exchange_mem_select_n, ram_bank_select_n,
              io_area_select_n, ext_area_select_n};
      if (prom_select_n === 1'b0 && (lanes.size() == 0 || lanes[$] !== byte_lane))
        lanes.push_back(byte_lane);
      if (resp.done === 1'b1) break;
      @(negedge core_clk);
      cyc++;
    end
    got_err = resp.err;
    if (n >= 20 || cyc >= 400) begin
      n_mismatch++;
      $display("[ERR] handshake expected done seen none");
      finish_test();
    end
  endtask

  ////////////////////////////////
  // Scenarios
  task automatic t_regions();
    logic [31:0] ra[13] = '{32'h0000_0000, 32'h0100_0000, 32'h01f0_0000, 32'h0201_8000,
      32'h0203_8000, 32'h0400_0000, 32'h1000_0000, 32'h1100_0000, 32'h1200_0000,
      32'h1300_0000, 32'h1400_0000, 32'h8000_0000, 32'h01f8_0000};
    int rk[13] = '{16, 16, 15, 8, 12, 0, 1, 2, 3, 4, 0, 0, -1};
    int rc[13] = '{2, 0, 0, 2, 2, 0, 2, 2, 2, 2, 0, 0, 1};
    for (int i = 0; i < 13; i++) begin
      acc(ra[i], `SZ_WORD, 1'b0, 32'h0);
      chk("select", 32'(one_sel(rk[i])), 32'(sel));
      chk("error", 32'(ERR_NONE), 32'(got_err));
      if (rc[i] != 0) chk("latency", rc[i], cyc);
      else chk("ready wait", 1, 32'(cyc > 2));
    end
    $display("regions done");
  endtask

  task automatic t_illegal();
    logic [31:0] ia[3] = '{32'h0002_0000, 32'h01f0_1000, 32'h0204_0000};
    for (int i = 0; i < 3; i++) begin
      acc(ia[i], `SZ_WORD, 1'b0, 32'h0);
      chk("error", 32'(ERR_ILLEGAL), 32'(got_err));
      chk("select", 32'h1ffff, 32'(sel));
      chk("latency", 1, cyc);
      chk("ready kept", 1, 32'(req_ready));
    end
    $display("illegal done");
  endtask

  task automatic t_sizes();
    logic [31:0] sa[9] = '{32'h0, 32'h0, 32'h01f0_0000, 32'h01f8_0004, 32'h01f8_0000,
      32'h0200_0001, 32'h0, 32'h3, 32'h1000_0000};
    logic [1:0] sz[9] = '{2'h0, 2'h2, 2'h1, 2'h0, 2'h2, 2'h0, 2'h2, 2'h0, 2'h3};
    logic [8:0] wr = 9'b011110111;
    logic [8:0] nw = 9'b100111111;
    logic [8:0] bad = 9'b011100010;
    for (int i = 0; i < 9; i++) begin
      narrow_n = nw[8 - i];
      acc(sa[i], sz[i], wr[8 - i], 32'h0);
      chk("error", bad[8 - i] ? 32'(ERR_SIZE) : 32'(ERR_NONE), 32'(got_err));
      if (bad[8 - i]) chk("select", 32'h1ffff, 32'(sel));
    end
    narrow_n = 1'b1;
    $display("sizes done");
  endtask

  task automatic t_parity();
    logic [31:0] d[2] = '{32'h0000_0007, 32'ha5a5_0003};
    for (int i = 0; i < 2; i++) begin
      acc(32'h0200_0000, `SZ_WORD, 1'b1, d[i]);
      chk("parity line", 32'(~^d[i]), 32'(data_parity_line));
      chk("parity on", 1, 32'(parity_active));
    end
    acc(32'h0000_0000, `SZ_WORD, 1'b1, 32'h1);
    chk("wide prom protect", 3, {30'h0, parity_active, edac_active});
    narrow_n = 1'b0;
    acc(32'h0000_0001, `SZ_BYTE, 1'b1, 32'h1);
    chk("narrow prom protect", 0, {30'h0, parity_active, edac_active});
    narrow_n = 1'b1;
    acc(32'h8000_0000, `SZ_WORD, 1'b1, 32'h3);
    chk("general parity", 0, {30'h0, parity_active, data_parity_line});
    en = 5'h0f;
    acc(32'h1000_0000, `SZ_WORD, 1'b1, 32'h1);
    chk("io parity off", 0, {30'h0, parity_active, data_parity_line});
    en = 5'h1f;
    $display("parity done");
  endtask

  task automatic t_timeout();
    stall = 1'b1;
    acc(32'h0400_0000, `SZ_WORD, 1'b0, 32'h0);
    chk("error", 32'(ERR_TIMEOUT), 32'(got_err));
    chk("timeout span", 1, 32'(cyc >= 256 && cyc <= 258));
    chk("select", 32'(one_sel(0)), 32'(sel));
    stall = 1'b0;
    $display("timeout done");
  endtask

  task automatic t_lanes();
    narrow_n = 1'b0;
    acc(32'h0000_0002, `SZ_WORD, 1'b0, 32'h0);
    chk("lane count", 4, lanes.size());
    for (int i = 0; i < lanes.size(); i++) chk("lane", (i + 2) % 4, 32'(lanes[i]));
    acc(32'h0100_0001, 2'h1, 1'b0, 32'h0);
    chk("ext lane count", 2, lanes.size());
    for (int i = 0; i < lanes.size(); i++) chk("ext lane", i + 1, 32'(lanes[i]));
    narrow_n = 1'b1;
    $display("lanes done");
  endtask

  ////////////////////////////////
  // Main sequence: reset for 5 cycles, then each scenario in turn
  initial begin
    rstn = 1'b0;
    req_valid = 1'b0;
    req = '0;
    narrow_n = 1'b1;
    stall = 1'b0;
    en = 5'h1f;
    n_mismatch = 0;
    checks = 0;
    repeat (5) @(negedge core_clk);
    rstn = 1'b1;
    t_regions();
    t_illegal();
    t_sizes();
    t_parity();
    t_timeout();
    t_lanes();
    finish_test();
  end
endmodule
